// *** src/measurement_config_cfg.svh ***
// constants for the measurement configuration register bank
// Overview of operation
// - each 3-bit filter code selects bypass at 0, then coefficients 1 to 127
// - filter, output-select and count-limit writes are ignored during a conversion
// - 17-bit range threshold split over bytes 0x32, 0x33 and bit 0 of 0x35
// - 8-bit read/write range width at 0x34, reset zero, used with the threshold
// - 2-bit count limit at bit 6 of 0x35 selects 1, 3, 7 or 15
// - temperature and pressure oversampling codes 0 to 7 mean 1x up to 128x
// - pressure enable set measures pressure, clear measures temperature only
// - power mode code: standby, normal, forced single, non-stop repetitive
// - normal mode starts on the rate grid, non-stop restarts after one idle cycle
// - a write requests a power mode, a read returns the mode in force
// - after a forced measurement the mode returns to standby
// - 5-bit rate code at bit 2 selects 240 Hz down to 0.125 Hz
// - deep standby disable at bit 7 of 0x37, locked during a conversion
// - every rate or oversampling write re-checks validity into bit 7
// - an invalid combination applies default oversampling instead
// - effective byte shows applied temperature and pressure oversampling codes
// - pressure out-of-range event shows as bit 3 of the status byte
// - a locked bit picks unfiltered or filtered pressure for the range check
`ifndef MEASUREMENT_CONFIG_CFG_SVH
`define MEASUREMENT_CONFIG_CFG_SVH

`define OFS_INT_STATUS   8'h27
`define OFS_DSP_SEL      8'h30
`define OFS_FILTER       8'h31
`define OFS_THR_LOW      8'h32
`define OFS_THR_HIGH     8'h33
`define OFS_RANGE        8'h34
`define OFS_RANGE_CFG    8'h35
`define OFS_OSR_CFG      8'h36
`define OFS_RATE_CFG     8'h37
`define OFS_OSR_EFF      8'h38

`define POS_IIR_T        0
`define POS_IIR_P        3
`define POS_OOR_SEL      7
`define POS_THR_BIT16    0
`define POS_CNT_LIM      6
`define POS_OSR_T        0
`define POS_OSR_P        3
`define POS_PRESS_EN     6
`define POS_PWR_MODE     0
`define POS_ODR          2
`define POS_DEEP_DIS     7
`define POS_VALID        7
`define POS_OOR_FLAG     3

`define RST_RATE_CFG     8'h70
`define RST_ZERO         8'h00
`define OSR_DEFAULT      3'h0

`define MODE_STANDBY     2'h0
`define MODE_NORMAL      2'h1
`define MODE_FORCED      2'h2
`define MODE_NONSTOP     2'h3

`define CLK_PERIOD_NS    10
`define TICK_NS          1000
`define US_TICK_CYCLES   (`TICK_NS / `CLK_PERIOD_NS)
`define CONV_UNIT_US     20

`endif

// *** src/measurement_config_pkg.sv ***
// types shared by the measurement configuration register bank
`default_nettype none
package measurement_config_pkg;
  typedef enum logic {
    SEQ_IDLE,
    SEQ_CONV
  } seq_state_t;
  typedef logic [22:0] period_us_t;
endpackage : measurement_config_pkg
`default_nettype wire

// *** src/measurement_config_bank.sv ***
// measurement configuration register bank with conversion sequencer and range check
`timescale 1ns/100ps
`default_nettype none
`include "measurement_config_cfg.svh"
module measurement_config_bank #(
  parameter int unsigned US_TICK_CYCLES = `US_TICK_CYCLES
) (
  input  wire  logic        core_clk_i,
  input  wire  logic        nrst_i,
  input  wire  logic        clk_en_i,
  input  wire  logic [7:0]  reg_addr_i,
  input  wire  logic [7:0]  reg_wdata_i,
  input  wire  logic        reg_wr_i,
  input  wire  logic        reg_rd_i,
  input  wire  logic [16:0] press_raw_i,
  input  wire  logic [16:0] press_filt_i,
  output logic [7:0]        rd_data_o,
  output logic              conv_busy_o,
  output logic              conv_done_o,
  output logic [6:0]        iir_coef_p_o,
  output logic [6:0]        iir_coef_t_o,
  output logic [2:0]        osr_t_eff_o,
  output logic [2:0]        osr_p_eff_o,
  output logic              press_en_o,
  output logic              deep_standby_dis_o,
  output logic              oor_event_o
);

  // measurement period per rate code, in microseconds, rounded down
  function automatic measurement_config_pkg::period_us_t odr_period_us(input logic [4:0] code);
    case (code)
      5'h00: odr_period_us = 23'h001046;
      5'h01: odr_period_us = 23'h0011DF;
      5'h02: odr_period_us = 23'h00139E;
      5'h03: odr_period_us = 23'h0015CC;
      5'h04: odr_period_us = 23'h00186A;
      5'h05: odr_period_us = 23'h001A28;
      5'h06: odr_period_us = 23'h001BE6;
      5'h07: odr_period_us = 23'h001E14;
      5'h08: odr_period_us = 23'h00208D;
      5'h09: odr_period_us = 23'h002375;
      5'h0A: odr_period_us = 23'h0026F2;
      5'h0B: odr_period_us = 23'h002B98;
      5'h0C: odr_period_us = 23'h0030D4;
      5'h0D: odr_period_us = 23'h0037CD;
      5'h0E: odr_period_us = 23'h00411A;
      5'h0F: odr_period_us = 23'h004E09;
      5'h10: odr_period_us = 23'h0056C1;
      5'h11: odr_period_us = 23'h0061A8;
      5'h12: odr_period_us = 23'h006F9B;
      5'h13: odr_period_us = 23'h008235;
      5'h14: odr_period_us = 23'h009C38;
      5'h15: odr_period_us = 23'h00C350;
      5'h16: odr_period_us = 23'h01046A;
      5'h17: odr_period_us = 23'h0186A0;
      5'h18: odr_period_us = 23'h030D40;
      5'h19: odr_period_us = 23'h03D090;
      5'h1A: odr_period_us = 23'h051615;
      5'h1B: odr_period_us = 23'h07A120;
      5'h1C: odr_period_us = 23'h0F4240;
      5'h1D: odr_period_us = 23'h1E8480;
      5'h1E: odr_period_us = 23'h3D0900;
      default: odr_period_us = 23'h7A1200;
    endcase
  endfunction : odr_period_us

  // conversion length in microseconds from oversampling codes
  function automatic logic [12:0] conv_us(input logic [2:0] ot, input logic [2:0] op,
                                          input logic pe);
    logic [12:0] sum;
    sum = (13'h0001 << ot) + (pe ? (13'h0001 << op) : 13'h0000);
    conv_us = 13'(`CONV_UNIT_US * sum);
  endfunction : conv_us

  // the tick counter runs free, so a conversion may come out up to one tick short
  localparam logic [15:0] TICK_LAST = 16'(US_TICK_CYCLES - 1);

  // register state
  logic        oor_sel_q;
  logic [2:0]  iir_t_q;
  logic [2:0]  iir_p_q;
  logic [16:0] thr_q;
  logic [7:0]  range_q;
  logic [1:0]  cnt_lim_q;
  logic [2:0]  osr_t_q;
  logic [2:0]  osr_p_q;
  logic        press_en_q;
  logic [4:0]  odr_q;
  logic        deep_dis_q;
  logic [1:0]  mode_q;
  logic        valid_q;
  logic [2:0]  eff_t_q;
  logic [2:0]  eff_p_q;
  logic        oor_q;
  logic [3:0]  oor_cnt_q;
  logic [7:0]  rd_data_q;
  logic [6:0]  coef_p_q;
  logic [6:0]  coef_t_q;
  logic        done_q;
  measurement_config_pkg::seq_state_t seq_q;
  logic        conv_forced_q;
  logic [15:0] us_cnt_q;
  logic [12:0] conv_left_q;
  logic [22:0] odr_left_q;
  logic        busy_q;

  // address decode
  wire wr_sel  = reg_wr_i && (reg_addr_i == `OFS_DSP_SEL);
  wire wr_filt = reg_wr_i && (reg_addr_i == `OFS_FILTER);
  wire wr_tlo  = reg_wr_i && (reg_addr_i == `OFS_THR_LOW);
  wire wr_thi  = reg_wr_i && (reg_addr_i == `OFS_THR_HIGH);
  wire wr_rng  = reg_wr_i && (reg_addr_i == `OFS_RANGE);
  wire wr_rcfg = reg_wr_i && (reg_addr_i == `OFS_RANGE_CFG);
  wire wr_osr  = reg_wr_i && (reg_addr_i == `OFS_OSR_CFG);
  wire wr_rate = reg_wr_i && (reg_addr_i == `OFS_RATE_CFG);
  wire rd_stat = reg_rd_i && (reg_addr_i == `OFS_INT_STATUS);
  wire busy    = (seq_q == measurement_config_pkg::SEQ_CONV);

  // locked fields keep their value while a conversion runs
  wire       lock_ok   = !busy;
  wire       oor_sel_d = (wr_sel && lock_ok) ? reg_wdata_i[`POS_OOR_SEL] : oor_sel_q;
  wire [2:0] iir_t_d   = (wr_filt && lock_ok) ? reg_wdata_i[`POS_IIR_T +: 3] : iir_t_q;
  wire [2:0] iir_p_d   = (wr_filt && lock_ok) ? reg_wdata_i[`POS_IIR_P +: 3] : iir_p_q;
  wire [1:0] cnt_lim_d = (wr_rcfg && lock_ok) ? reg_wdata_i[`POS_CNT_LIM +: 2] : cnt_lim_q;
  wire       deep_d    = (wr_rate && lock_ok) ? reg_wdata_i[`POS_DEEP_DIS] : deep_dis_q;
  wire [16:0] thr_d    = {wr_rcfg ? reg_wdata_i[`POS_THR_BIT16] : thr_q[16],
                          wr_thi ? reg_wdata_i : thr_q[15:8],
                          wr_tlo ? reg_wdata_i : thr_q[7:0]};
  wire [7:0] range_d   = wr_rng ? reg_wdata_i : range_q;
  wire [2:0] osr_t_d   = wr_osr ? reg_wdata_i[`POS_OSR_T +: 3] : osr_t_q;
  wire [2:0] osr_p_d   = wr_osr ? reg_wdata_i[`POS_OSR_P +: 3] : osr_p_q;
  wire       press_d   = wr_osr ? reg_wdata_i[`POS_PRESS_EN] : press_en_q;
  wire [4:0] odr_d     = wr_rate ? reg_wdata_i[`POS_ODR +: 5] : odr_q;

  // combination check on the values being written
  wire [12:0] cfg_us   = conv_us(osr_t_d, osr_p_d, press_d);
  wire        combo_ok = ({10'h000, cfg_us} < odr_period_us(odr_d));
  wire        recheck  = wr_osr || wr_rate;
  wire        valid_d  = recheck ? combo_ok : valid_q;
  wire [2:0]  eff_t_d  = recheck ? (combo_ok ? osr_t_d : `OSR_DEFAULT) : eff_t_q;
  wire [2:0]  eff_p_d  = recheck ? (combo_ok ? osr_p_d : `OSR_DEFAULT) : eff_p_q;

  // sequencer timing
  wire tick    = (us_cnt_q == TICK_LAST);
  wire conv_end = busy && tick && (conv_left_q == 13'h0001);
  wire start   = !busy && ((mode_q == `MODE_FORCED) || (mode_q == `MODE_NONSTOP) ||
                 ((mode_q == `MODE_NORMAL) && (odr_left_q == 23'h000000)));
  wire [12:0] eff_us = conv_us(eff_t_q, eff_p_q, press_en_q);
  wire [12:0] conv_left_d = start ? eff_us :
                            (busy && tick) ? 13'(conv_left_q - 13'h0001) : conv_left_q;
  // odr counter idles at zero outside normal so that entering normal starts at once
  wire [22:0] odr_left_d = (mode_q != `MODE_NORMAL) ? 23'h000000 :
                           start ? odr_period_us(odr_q) :
                           (tick && odr_left_q != 23'h000000) ? 23'(odr_left_q - 23'h000001) :
                           odr_left_q;
  wire [15:0] us_cnt_d = tick ? 16'h0000 : 16'(us_cnt_q + 16'h0001);
  // two-state sequencer, a start can only come from idle
  measurement_config_pkg::seq_state_t seq_d;
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      measurement_config_pkg::SEQ_IDLE: begin
        if (start) begin
          seq_d = measurement_config_pkg::SEQ_CONV;
        end
      end
      measurement_config_pkg::SEQ_CONV: begin
        if (conv_end) begin
          seq_d = measurement_config_pkg::SEQ_IDLE;
        end
      end
      default: begin
        seq_d = measurement_config_pkg::SEQ_IDLE;
      end
    endcase
  end
  // only a conversion launched by a forced request may drop the mode back to standby
  wire conv_forced_d = start ? (mode_q == `MODE_FORCED) : conv_forced_q;

  // host write wins over the automatic return to standby in the same cycle
  wire [1:0] mode_d = wr_rate ? reg_wdata_i[`POS_PWR_MODE +: 2] :
                      (conv_end && conv_forced_q && mode_q == `MODE_FORCED) ? `MODE_STANDBY :
                      mode_q;

  // range check on the selected pressure source at the end of a conversion
  wire [16:0] p_sel   = oor_sel_q ? press_filt_i : press_raw_i;
  wire [17:0] win_hi  = {1'b0, thr_q} + {10'h000, range_q};
  wire [17:0] win_lo  = ({10'h000, range_q} > {1'b0, thr_q}) ? 18'h00000 :
                        18'({1'b0, thr_q} - {10'h000, range_q});
  wire        p_out   = ({1'b0, p_sel} > win_hi) || ({1'b0, p_sel} < win_lo);
  wire [3:0]  lim     = 4'((5'h02 << cnt_lim_q) - 5'h01);
  wire [3:0]  cnt_inc = (oor_cnt_q == 4'hF) ? 4'hF : 4'(oor_cnt_q + 4'h1);
  wire        judge   = conv_end && press_en_q;
  wire        oor_hit = judge && p_out && (cnt_inc >= lim);
  wire [3:0]  oor_cnt_d = judge ? (p_out ? cnt_inc : 4'h0) : oor_cnt_q;
  wire        oor_d   = oor_hit ? 1'b1 : (rd_stat ? 1'b0 : oor_q);

  // read selection, unmapped addresses read zero
  wire [7:0] rd_mux =
    (reg_addr_i == `OFS_INT_STATUS) ? (8'h00 | (8'(oor_q) << `POS_OOR_FLAG)) :
    (reg_addr_i == `OFS_DSP_SEL)    ? {oor_sel_q, 7'h00} :
    (reg_addr_i == `OFS_FILTER)     ? {2'h0, iir_p_q, iir_t_q} :
    (reg_addr_i == `OFS_THR_LOW)    ? thr_q[7:0] :
    (reg_addr_i == `OFS_THR_HIGH)   ? thr_q[15:8] :
    (reg_addr_i == `OFS_RANGE)      ? range_q :
    (reg_addr_i == `OFS_RANGE_CFG)  ? {cnt_lim_q, 5'h00, thr_q[16]} :
    (reg_addr_i == `OFS_OSR_CFG)    ? {1'b0, press_en_q, osr_p_q, osr_t_q} :
    (reg_addr_i == `OFS_RATE_CFG)   ? {deep_dis_q, odr_q, mode_q} :
    (reg_addr_i == `OFS_OSR_EFF)    ? {valid_q, 1'b0, eff_p_q, eff_t_q} :
    8'h00;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oor_sel_q  <= 1'b0;
      iir_t_q    <= 3'h0;
      iir_p_q    <= 3'h0;
      thr_q      <= 17'h00000;
      range_q    <= `RST_ZERO;
      cnt_lim_q  <= 2'h0;
      osr_t_q    <= 3'h0;
      osr_p_q    <= 3'h0;
      press_en_q <= 1'b0;
      odr_q      <= 5'(`RST_RATE_CFG >> `POS_ODR);
      deep_dis_q <= 1'b0;
    end else if (clk_en_i) begin
      oor_sel_q  <= oor_sel_d;
      iir_t_q    <= iir_t_d;
      iir_p_q    <= iir_p_d;
      thr_q      <= thr_d;
      range_q    <= range_d;
      cnt_lim_q  <= cnt_lim_d;
      osr_t_q    <= osr_t_d;
      osr_p_q    <= osr_p_d;
      press_en_q <= press_d;
      odr_q      <= odr_d;
      deep_dis_q <= deep_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      valid_q <= 1'b0;
      eff_t_q <= 3'h0;
      eff_p_q <= 3'h0;
      mode_q  <= `MODE_STANDBY;
      oor_q   <= 1'b0;
      oor_cnt_q <= 4'h0;
    end else if (clk_en_i) begin
      valid_q <= valid_d;
      eff_t_q <= eff_t_d;
      eff_p_q <= eff_p_d;
      mode_q  <= mode_d;
      oor_q   <= oor_d;
      oor_cnt_q <= oor_cnt_d;
    end
  end

  // busy flop follows the next state, so the pin leaves a flop in step with seq_q
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_q         <= measurement_config_pkg::SEQ_IDLE;
      conv_forced_q <= 1'b0;
      us_cnt_q      <= 16'h0000;
      conv_left_q   <= 13'h0000;
      odr_left_q    <= 23'h000000;
      done_q        <= 1'b0;
      busy_q        <= 1'b0;
    end else if (clk_en_i) begin
      seq_q         <= seq_d;
      busy_q        <= (seq_d == measurement_config_pkg::SEQ_CONV);
      conv_forced_q <= conv_forced_d;
      us_cnt_q      <= us_cnt_d;
      conv_left_q   <= conv_left_d;
      odr_left_q    <= odr_left_d;
      done_q        <= conv_end;
    end
  end

  // coefficient is two to the code minus one, which also gives zero for bypass
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_q <= 8'h00;
      coef_p_q  <= 7'h00;
      coef_t_q  <= 7'h00;
    end else if (clk_en_i) begin
      rd_data_q <= reg_rd_i ? rd_mux : 8'h00;
      coef_p_q  <= 7'((8'h01 << iir_p_q) - 8'h01);
      coef_t_q  <= 7'((8'h01 << iir_t_q) - 8'h01);
    end
  end

  assign rd_data_o          = rd_data_q;
  assign conv_busy_o        = busy_q;
  assign conv_done_o        = done_q;
  assign iir_coef_p_o       = coef_p_q;
  assign iir_coef_t_o       = coef_t_q;
  assign osr_t_eff_o        = eff_t_q;
  assign osr_p_eff_o        = eff_p_q;
  assign press_en_o         = press_en_q;
  assign deep_standby_dis_o = deep_dis_q;
  assign oor_event_o        = oor_q;

  default clocking chk_clk @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_filter_locked: assert property (clk_en_i && busy && wr_filt |=>
    $stable(iir_t_q) && $stable(iir_p_q)) else $error("filter field changed during conversion");
  chk_thr_split: assert property (clk_en_i && wr_thi |=>
    thr_q[15:8] == $past(reg_wdata_i) && thr_q[16] == $past(thr_q[16]))
    else $error("threshold high byte not stored");
  chk_range_store: assert property (clk_en_i && wr_rng |=> range_q == $past(reg_wdata_i))
    else $error("range width not stored");
  chk_cnt_locked: assert property (clk_en_i && busy && wr_rcfg |=> $stable(cnt_lim_q))
    else $error("count limit changed during conversion");
  chk_deep_locked: assert property (clk_en_i && busy && wr_rate |=> $stable(deep_dis_q))
    else $error("deep standby disable changed during conversion");
  chk_eff_valid: assert property (clk_en_i && recheck |=>
    valid_q == $past(combo_ok) && (valid_q ? eff_t_q == osr_t_q && eff_p_q == osr_p_q
    : eff_t_q == 3'h0 && eff_p_q == 3'h0)) else $error("effective settings wrong after write");
  chk_forced_back: assert property (clk_en_i && conv_end && conv_forced_q &&
    mode_q == `MODE_FORCED && !wr_rate |=> mode_q == `MODE_STANDBY && conv_done_o)
    else $error("forced measurement did not return to standby");
  chk_nonstop_again: assert property (conv_done_o && clk_en_i && mode_q == `MODE_NONSTOP
    && !wr_rate |=> conv_busy_o) else $error("non-stop mode idled after a conversion");
  chk_mode_read: assert property (clk_en_i && reg_rd_i && reg_addr_i == `OFS_RATE_CFG |=>
    rd_data_o[1:0] == $past(mode_q)) else $error("mode read does not show mode in force");
  chk_oor_sticky: assert property (oor_q && !(clk_en_i && rd_stat) |=> oor_q)
    else $error("range flag lost without a status read");

  // coefficients, register stores and read-back
  chk_coef_bypass: assert property (clk_en_i && iir_p_q == 3'h0 |=>
    iir_coef_p_o == 7'h00) else $error("bypass code gave a nonzero coefficient");
  chk_coef_top: assert property (clk_en_i && iir_t_q == 3'h7 |=>
    iir_coef_t_o == 7'h7F) else $error("top filter code gave a wrong coefficient");
  chk_thr_low: assert property (clk_en_i && wr_tlo |=>
    thr_q[7:0] == $past(reg_wdata_i)) else $error("threshold low byte not stored");
  chk_thr_bit16: assert property (clk_en_i && wr_rcfg |=>
    thr_q[16] == $past(reg_wdata_i[`POS_THR_BIT16])) else $error("threshold bit 16 not stored");
  chk_osr_store: assert property (clk_en_i && wr_osr |=>
    {press_en_q, osr_p_q, osr_t_q} == $past(reg_wdata_i[6:0]))
    else $error("oversampling byte not stored");
  chk_odr_store: assert property (clk_en_i && wr_rate |=>
    odr_q == $past(reg_wdata_i[`POS_ODR +: 5])) else $error("rate code not stored");
  chk_eff_read: assert property (clk_en_i && reg_rd_i &&
    reg_addr_i == `OFS_OSR_EFF |=> rd_data_o == {$past(valid_q), 1'b0, $past(eff_p_q),
    $past(eff_t_q)}) else $error("effective byte read back wrong");
  chk_read_once: assert property (clk_en_i && !reg_rd_i |=> rd_data_o == 8'h00)
    else $error("read data stood longer than one cycle");
  // locks and sequencer
  chk_oor_sel_locked: assert property (clk_en_i && busy && wr_sel |=>
    $stable(oor_sel_q)) else $error("range source changed during conversion");
  chk_forced_start: assert property (clk_en_i && !busy && mode_q == `MODE_FORCED |=>
    conv_busy_o) else $error("forced request did not start a conversion");
  chk_normal_start: assert property (clk_en_i && !busy && mode_q == `MODE_NORMAL &&
    odr_left_q == 23'h000000 |=> conv_busy_o) else $error("normal mode missed its grid start");
  chk_clock_freeze: assert property (!clk_en_i |=> $stable(mode_q) && $stable(seq_q) &&
    $stable(thr_q)) else $error("state moved while the clock enable was low");
  // range check
  chk_window_reset: assert property (clk_en_i && judge && !p_out |=> oor_cnt_q == 4'h0)
    else $error("count not cleared by an in-window sample");
  chk_temp_only: assert property (clk_en_i && conv_end && !press_en_q |=>
    $stable(oor_cnt_q)) else $error("range count moved in temperature-only mode");

  cov_forced_run: cover property (mode_q == `MODE_FORCED ##1 conv_busy_o ##[1:1000] conv_done_o);
  cov_invalid_combo: cover property (clk_en_i && recheck && !combo_ok);
  cov_oor_set: cover property (!oor_q ##1 oor_q);
  cov_locked_write: cover property (clk_en_i && busy && wr_filt);
  cov_nonstop_chain: cover property (conv_done_o && mode_q == `MODE_NONSTOP ##1 conv_busy_o);

endmodule : measurement_config_bank
`default_nettype wire

// *** verif/host_reg_model.sv ***
// host side model driving the register port of the configuration bank
`timescale 1ns/100ps
`default_nettype none
module host_reg_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rd_data_i,
  output var  logic [7:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o,
  output var  logic       reg_wr_o,
  output var  logic       reg_rd_o
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // idle address and data are inverted so nothing stale looks like a request
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_i);
    reg_addr_o  <= addr;
    reg_wdata_o <= data;
    reg_wr_o    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~addr;
    reg_wdata_o <= ~data;
  endtask : write_reg

  // read data stand only in the cycle after the strobe, so take them there
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge core_clk_i);
    reg_addr_o <= addr;
    reg_rd_o   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~addr;
    #1;
    data = rd_data_i;
  endtask : read_reg

  // a rate or oversampling write made here is followed by a look at the validity byte
  task automatic write_and_validity(input logic [7:0] addr, input logic [7:0] data,
                                    output logic [7:0] eff);
    write_reg(addr, data);
    read_reg(8'h38, eff);
  endtask : write_and_validity
endmodule : host_reg_model
`default_nettype wire

// *** verif/measurement_config_bank_test.sv ***
// self-checking bench for the measurement configuration register bank
`timescale 1ns/100ps
`default_nettype none
module measurement_config_bank_test;
  logic        core_clk_i;
  logic        nrst_i;
  logic        clk_en_i;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [16:0] press_raw;
  logic [16:0] press_filt;
  logic [7:0]  rd_data;
  logic        conv_busy;
  logic        conv_done;
  logic [6:0]  coef_p;
  logic [6:0]  coef_t;
  logic [2:0]  osr_t_eff;
  logic [2:0]  osr_p_eff;
  logic        press_en;
  logic        deep_dis;
  logic        oor_event;
  logic [7:0]  eff;
  int          n_fail;
  int          checks_done;
  logic [7:0]  wr_v [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hFF};
  logic [7:0]  rd_v [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC1};

  // short tick keeps conversions to tens of cycles
  measurement_config_bank #(.US_TICK_CYCLES(2)) DUT (
    .core_clk_i        (core_clk_i),
    .nrst_i            (nrst_i),
    .clk_en_i          (clk_en_i),
    .reg_addr_i        (reg_addr),
    .reg_wdata_i       (reg_wdata),
    .reg_wr_i          (reg_wr),
    .reg_rd_i          (reg_rd),
    .press_raw_i       (press_raw),
    .press_filt_i      (press_filt),
    .rd_data_o         (rd_data),
    .conv_busy_o       (conv_busy),
    .conv_done_o       (conv_done),
    .iir_coef_p_o      (coef_p),
    .iir_coef_t_o      (coef_t),
    .osr_t_eff_o       (osr_t_eff),
    .osr_p_eff_o       (osr_p_eff),
    .press_en_o        (press_en),
    .deep_standby_dis_o(deep_dis),
    .oor_event_o       (oor_event)
  );

  host_reg_model host (
    .core_clk_i (core_clk_i),
    .rd_data_i  (rd_data),
    .reg_addr_o (reg_addr),
    .reg_wdata_o(reg_wdata),
    .reg_wr_o   (reg_wr),
    .reg_rd_o   (reg_rd)
  );

  always #5 core_clk_i = ~core_clk_i;

  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic check_val(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_val

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    host.read_reg(addr, v);
    check_val($sformatf("reg %h", addr), v, exp);
  endtask : rd_chk

  // a hung sequencer ends the run instead of stalling it
  task automatic wait_level(input bit want_done, input int bound);
    int n;
    for (n = 0; n < bound; n++) begin
      @(posedge core_clk_i);
      if (want_done ? (conv_done === 1'b1) : (conv_busy === 1'b0)) break;
    end
    if (n == bound) begin
      n_fail++;
      $display("Error wait sequencer expected event seen none");
      tally_and_finish();
    end
  endtask : wait_level

  initial begin
    core_clk_i = 1'b0;
    nrst_i     = 1'b0;
    clk_en_i   = 1'b1;
    press_raw  = 17'h00000;
    press_filt = 17'h00000;
    n_fail      = 0;
    checks_done = 0;
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(8'h31 + i[7:0], (i == 6) ? 8'h70 : 8'h00);
    rd_chk(8'h38, 8'h00);
    rd_chk(8'h40, 8'h00);
    for (int c = 0; c < 8; c++) begin
      host.write_reg(8'h31, {2'h0, c[2:0], c[2:0]});
      repeat (2) @(posedge core_clk_i);
      check_val("coef p", {1'b0, coef_p}, (8'h01 << c) - 8'h01);
      check_val("coef t", {1'b0, coef_t}, (8'h01 << c) - 8'h01);
    end
    host.write_reg(8'h31, 8'hFF);
    rd_chk(8'h31, 8'h3F);
    host.write_reg(8'h31, 8'h09);
    for (int i = 0; i < 4; i++) host.write_reg(8'h32 + i[7:0], wr_v[i]);
    for (int i = 0; i < 4; i++) rd_chk(8'h32 + i[7:0], rd_v[i]);
    host.write_and_validity(8'h36, 8'h7F, eff);
    check_val("eff slow rate", eff, 8'hBF);
    check_val("press en", {7'h00, press_en}, 8'h01);
    check_val("osr t eff", {5'h00, osr_t_eff}, 8'h07);
    rd_chk(8'h36, 8'h7F);
    host.write_and_validity(8'h37, 8'h00, eff);
    check_val("eff invalid", eff, 8'h00);
    check_val("osr p eff", {5'h00, osr_p_eff}, 8'h00);
    host.write_and_validity(8'h36, 8'h00, eff);
    check_val("eff fast rate", eff, 8'h80);
    check_val("press en", {7'h00, press_en}, 8'h00);
    host.write_reg(8'h37, 8'hF0);
    // the pin settles in the write edge's own time step, so look after the read
    rd_chk(8'h37, 8'hF0);
    check_val("deep dis", {7'h00, deep_dis}, 8'h01);
    // forced: writes to locked fields during the conversion must not land
    host.write_reg(8'h35, 8'h01);
    host.write_reg(8'h37, 8'h72);
    rd_chk(8'h37, 8'h72);
    check_val("busy forced", {7'h00, conv_busy}, 8'h01);
    host.write_reg(8'h31, 8'h3F);
    host.write_reg(8'h35, 8'hC0);
    host.write_reg(8'h30, 8'h80);
    wait_level(1'b1, 300);
    repeat (2) @(posedge core_clk_i);
    rd_chk(8'h37, 8'h70);
    rd_chk(8'h31, 8'h09);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h30, 8'h00);
    host.write_reg(8'h37, 8'h71);
    repeat (3) @(posedge core_clk_i);
    check_val("busy normal", {7'h00, conv_busy}, 8'h01);
    rd_chk(8'h37, 8'h71);
    host.write_reg(8'h37, 8'hF0);
    wait_level(1'b0, 300);
    rd_chk(8'h37, 8'h70);
    // raw sample above threshold plus range, filtered one inside: raw is selected
    host.write_reg(8'h30, 8'h00);
    host.write_reg(8'h32, 8'h00);
    host.write_reg(8'h33, 8'h00);
    host.write_reg(8'h34, 8'h10);
    host.write_reg(8'h35, 8'h41);
    host.write_reg(8'h36, 8'h40);
    press_raw  <= 17'h10011;
    press_filt <= 17'h10000;
    host.write_reg(8'h37, 8'h73);
    repeat (2) wait_level(1'b1, 300);
    repeat (2) @(posedge core_clk_i);
    check_val("oor after two", {7'h00, oor_event}, 8'h00);
    wait_level(1'b1, 300);
    repeat (2) @(posedge core_clk_i);
    check_val("oor after three", {7'h00, oor_event}, 8'h01);
    host.write_reg(8'h37, 8'h70);
    wait_level(1'b0, 300);
    rd_chk(8'h27, 8'h08);
    rd_chk(8'h27, 8'h00);
    check_val("oor cleared", {7'h00, oor_event}, 8'h00);
    // filtered source selected: inside first, then below the window
    host.write_reg(8'h30, 8'h80);
    host.write_reg(8'h35, 8'h01);
    host.write_reg(8'h37, 8'h72);
    wait_level(1'b1, 300);
    repeat (2) @(posedge core_clk_i);
    check_val("oor filt inside", {7'h00, oor_event}, 8'h00);
    press_filt <= 17'h0FFEF;
    host.write_reg(8'h37, 8'h72);
    wait_level(1'b1, 300);
    repeat (2) @(posedge core_clk_i);
    check_val("oor filt below", {7'h00, oor_event}, 8'h01);
    // a write seen while the clock enable is low is lost
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    host.write_reg(8'h34, 8'h55);
    clk_en_i <= 1'b1;
    rd_chk(8'h34, 8'h10);
    tally_and_finish();
  end
endmodule : measurement_config_bank_test
`default_nettype wire
